// *** logic/rcm_cfg.svh ***
// Constants of the reset and clock source manager.
`ifndef RCM_CFG_SVH
`define RCM_CFG_SVH
`define RCM_DELAY_SHORT 13'd256
`define RCM_DELAY_LONG 13'd4096
`define RCM_FETCH_CYCLES 2'd2
`define RCM_VEC_LO_ADDR 16'hfffe
`define RCM_VEC_HI_ADDR 16'hffff
`define RCM_OUT_WIDTH_NS 1000
`define RCM_CLK_PERIOD_NS 50
`define RCM_OUT_WIDTH_CYC ((`RCM_OUT_WIDTH_NS + `RCM_CLK_PERIOD_NS - 1) / `RCM_CLK_PERIOD_NS)
`define RCM_SRC_EXT 3'h0
`define RCM_SRC_RC 3'h5
`endif

// *** logic/rcm_pkg.sv ***
// Types of the reset and clock source manager.
package rcm_pkg;
    typedef enum logic [1:0] {ST_ACTIVE, ST_DELAY, ST_FETCH, ST_RUN} rcm_phase_t;
    typedef struct packed {
        rcm_phase_t phase;
        logic [12:0] cnt;
        logic [7:0] width_cnt;
        logic rst_drive;
        logic pin_sync_a;
        logic pin_sync_b;
        logic clk_div;
        logic clk_out;
        logic vec_rd;
        logic [15:0] vec_addr;
        logic [7:0] vec_lo;
        logic [15:0] pc;
        logic cpu_run;
        logic osc_en;
        logic dbl_used;
    } rcm_state_t;
endpackage : rcm_pkg

// *** logic/rcm_top.sv ***
// Reset sequencer and clock source selection of the microcontroller.
//
// Behaviour
// - Doubler enabled with 2-4 MHz input: internal clock is twice the input.
// - Doubler disabled: internal clock is the selected oscillator divided by two.
// - Doubler set by one-time setting only; never used with the RC oscillator.
// - Main source picked by one-time setting: external, four resonators, or RC.
// - Resonators keep running while the device is in reset.
// - External pin, low-voltage detector and watchdog resets all act on the pin.
// - Reset pin is driven low throughout the stabilisation delay.
// - Reset routine address is fetched from FFFEh-FFFFh.
// - Each reset runs active phase, stabilisation delay, then vector fetch.
// - Stabilisation delay is 256 or 4096 CPU cycles, chosen by one-time setting.
// - Vector fetch takes exactly two clock cycles before execution starts.
// - Reset pin is open drain, driven only low, and sensed as input.
// - External low pulse is caught without a running clock.
// - A recognised external pulse is stretched to the minimum output reset width.
// - Watchdog underflow drives the pin low for the minimum output width.
// - Low-voltage reset holds the pin low while it is active.
`timescale 1ns/1ps
`include "rcm_cfg.svh"

module rcm_top
    import rcm_pkg::*;
#(
    parameter int OUT_WIDTH_CYC = `RCM_OUT_WIDTH_CYC
) (
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    input wire logic [2:0] CLOCK_SOURCE_SELECT_I,
    input wire logic DOUBLER_OPT_I,
    input wire logic LONG_DELAY_OPT_I,
    input wire logic SELECTED_OSC_CLK_I,
    input wire logic DOUBLER_CLK_I,
    input wire logic RESET_PIN_I,
    input wire logic EXT_RESET_LATCH_I,
    input wire logic LOW_VOLTAGE_DETECTOR_I,
    input wire logic WATCHDOG_UNDERFLOW_I,
    input wire logic [7:0] VEC_DATA_I,
    output logic RESET_PIN_O,
    output logic RESET_PIN_OE_N_O,
    output logic DOUBLED_OR_HALVED_CLOCK_O,
    output logic DOUBLER_ACTIVE_O,
    output logic RESONATOR_EN_O,
    output logic VEC_RD_O,
    output logic [15:0] VEC_ADDR_O,
    output logic [15:0] START_PC_O,
    output logic CPU_RUN_O,
    output logic [1:0] PHASE_O
);

    rcm_state_t s_r;
    rcm_state_t s_nxt;
    logic ext_req;
    logic src_active;
    logic [12:0] delay_len;

    // The pin is sensed through two flops; only the second is looked at.
    // EXT_RESET_LATCH_I comes from an asynchronous pad latch that needs no clock.
    assign ext_req = ~s_r.pin_sync_b | EXT_RESET_LATCH_I;
    assign src_active = ext_req | LOW_VOLTAGE_DETECTOR_I | WATCHDOG_UNDERFLOW_I;
    assign delay_len = LONG_DELAY_OPT_I ? `RCM_DELAY_LONG : `RCM_DELAY_SHORT;

    // Codes one to four pick a resonator; external, RC and unused codes do not.
    function automatic logic is_resonator(input logic [2:0] sel);
        return (sel != `RCM_SRC_EXT) && (sel != `RCM_SRC_RC) && (sel <= 3'h4);
    endfunction : is_resonator

    always_comb begin
        s_nxt = s_r;
        // Our own low drive is masked so that it cannot re-trigger the sequence.
        s_nxt.pin_sync_a = RESET_PIN_I | s_r.rst_drive;
        s_nxt.pin_sync_b = s_r.pin_sync_a;
        s_nxt.vec_rd = 1'b0;
        // Resonators stay on in every phase, reset included.
        s_nxt.osc_en = is_resonator(CLOCK_SOURCE_SELECT_I);
        // The doubler never runs with the RC source.
        s_nxt.dbl_used = DOUBLER_OPT_I && (CLOCK_SOURCE_SELECT_I != `RCM_SRC_RC);
        if (s_r.dbl_used) begin
            s_nxt.clk_out = DOUBLER_CLK_I;
        end else begin
            if (SELECTED_OSC_CLK_I && !s_r.clk_div) begin
                s_nxt.clk_out = ~s_r.clk_out;
            end
        end
        s_nxt.clk_div = SELECTED_OSC_CLK_I;
        if (s_r.width_cnt != 8'h00) begin
            s_nxt.width_cnt = s_r.width_cnt - 8'h01;
        end
        if (ext_req || WATCHDOG_UNDERFLOW_I) begin
            s_nxt.width_cnt = 8'(OUT_WIDTH_CYC);
        end
        unique case (s_r.phase)
            ST_ACTIVE: begin
                s_nxt.rst_drive = 1'b1;
                s_nxt.cnt = 13'h0000;
                if (!src_active && s_r.width_cnt == 8'h00) begin
                    s_nxt.phase = ST_DELAY;
                end
            end
            ST_DELAY: begin
                s_nxt.rst_drive = 1'b1;
                s_nxt.cnt = s_r.cnt + 13'h0001;
                if (s_r.cnt == delay_len - 13'h0001) begin
                    s_nxt.phase = ST_FETCH;
                    s_nxt.cnt = 13'h0000;
                    s_nxt.rst_drive = 1'b0;
                    s_nxt.vec_rd = 1'b1;
                    s_nxt.vec_addr = `RCM_VEC_LO_ADDR;
                end
            end
            ST_FETCH: begin
                s_nxt.rst_drive = 1'b0;
                s_nxt.cnt = s_r.cnt + 13'h0001;
                if (s_r.cnt == 13'h0000) begin
                    s_nxt.vec_lo = VEC_DATA_I;
                    s_nxt.vec_rd = 1'b1;
                    s_nxt.vec_addr = `RCM_VEC_HI_ADDR;
                end else begin
                    s_nxt.pc = {s_r.vec_lo, VEC_DATA_I};
                    s_nxt.phase = ST_RUN;
                    s_nxt.cpu_run = 1'b1;
                end
            end
            ST_RUN: begin
                s_nxt.rst_drive = 1'b0;
            end
        endcase
        if (src_active) begin
            s_nxt.phase = ST_ACTIVE;
            s_nxt.rst_drive = 1'b1;
            s_nxt.cpu_run = 1'b0;
            s_nxt.vec_rd = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            s_r <= '{phase: ST_ACTIVE, rst_drive: 1'b1, pin_sync_a: 1'b1, pin_sync_b: 1'b1,
                     osc_en: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign RESET_PIN_O = 1'b0;
    // Open drain: enable is active low, so driving low means enable at zero.
    assign RESET_PIN_OE_N_O = ~s_r.rst_drive;
    assign DOUBLED_OR_HALVED_CLOCK_O = s_r.clk_out;
    assign DOUBLER_ACTIVE_O = s_r.dbl_used;
    assign RESONATOR_EN_O = s_r.osc_en;
    assign VEC_RD_O = s_r.vec_rd;
    assign VEC_ADDR_O = s_r.vec_addr;
    assign START_PC_O = s_r.pc;
    assign CPU_RUN_O = s_r.cpu_run;
    assign PHASE_O = s_r.phase;

    int unsigned low_cnt;
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || s_r.rst_drive == 1'b0) begin
            low_cnt <= 0;
        end else if (low_cnt < 10000) begin
            low_cnt <= low_cnt + 1;
        end
    end

    AST_DELAY_DRIVES: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.phase == ST_DELAY |-> !RESET_PIN_OE_N_O)
        else $error("Reset pin released during delay.");
    AST_FETCH_TWO: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        ($rose(s_r.phase == ST_FETCH) && !src_active) ##1 !src_active |=> s_r.phase == ST_RUN)
        else $error("Fetch did not take two cycles.");
    AST_VEC_LO: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        $rose(s_r.phase == ST_FETCH) |-> VEC_RD_O && VEC_ADDR_O == 16'hfffe)
        else $error("Low vector address wrong.");
    AST_VEC_HI: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.phase == ST_FETCH && s_r.cnt == 13'h0001 |-> VEC_ADDR_O == 16'hffff)
        else $error("High vector address wrong.");
    AST_SRC_ACTS: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        (LOW_VOLTAGE_DETECTOR_I || WATCHDOG_UNDERFLOW_I) |=> !RESET_PIN_OE_N_O && !CPU_RUN_O)
        else $error("Reset source did not reach the pin.");
    AST_LVD_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        LOW_VOLTAGE_DETECTOR_I [*2] |-> s_r.phase == ST_ACTIVE)
        else $error("Low-voltage reset left active phase.");
    AST_NO_EARLY: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.phase == ST_ACTIVE && src_active |=> s_r.phase == ST_ACTIVE)
        else $error("Delay began with a source active.");
    AST_DELAY_LEN: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        $rose(s_r.phase == ST_FETCH) |-> low_cnt >= 256)
        else $error("Delay shorter than 256 cycles.");
    AST_WIDTH: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        WATCHDOG_UNDERFLOW_I |=> s_r.width_cnt == 8'(OUT_WIDTH_CYC))
        else $error("Output width not loaded.");
    AST_RC_NO_DBL: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        $past(CLOCK_SOURCE_SELECT_I) == 3'h5 |-> !DOUBLER_ACTIVE_O)
        else $error("Doubler used with RC source.");

    COV_RUN: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I) $rose(CPU_RUN_O));
    COV_WDG: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        WATCHDOG_UNDERFLOW_I && CPU_RUN_O);
    COV_EXT: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        !RESET_PIN_I && s_r.phase == ST_RUN);
    COV_LONG: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        $rose(s_r.phase == ST_FETCH) && LONG_DELAY_OPT_I);
    COV_DBL: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        DOUBLER_ACTIVE_O && CPU_RUN_O);

    // Clock path checks.

    AST_HALVE_TOGGLE: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        !s_r.dbl_used && SELECTED_OSC_CLK_I && !s_r.clk_div |=>
        DOUBLED_OR_HALVED_CLOCK_O == !$past(DOUBLED_OR_HALVED_CLOCK_O))
        else $error("Halved clock did not toggle.");

    AST_HALVE_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        !s_r.dbl_used && !(SELECTED_OSC_CLK_I && !s_r.clk_div) |=>
        $stable(DOUBLED_OR_HALVED_CLOCK_O))
        else $error("Halved clock changed between oscillator edges.");

    AST_DBL_FOLLOW: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.dbl_used |=> DOUBLED_OR_HALVED_CLOCK_O == $past(DOUBLER_CLK_I))
        else $error("Doubled clock not passed on.");

    AST_DBL_OPT: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        !DOUBLER_OPT_I |=> !DOUBLER_ACTIVE_O)
        else $error("Doubler active without its setting.");

    AST_RES_EN: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        1'b1 |=> RESONATOR_EN_O == is_resonator($past(CLOCK_SOURCE_SELECT_I)))
        else $error("Resonator enable does not match the source.");

    AST_RES_IN_RESET: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        is_resonator(CLOCK_SOURCE_SELECT_I) && src_active |=> RESONATOR_EN_O)
        else $error("Resonator stopped during reset.");

    AST_OSC_EXT_OFF: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        CLOCK_SOURCE_SELECT_I == `RCM_SRC_EXT |=> !RESONATOR_EN_O)
        else $error("Resonator enabled with external clock.");

    // Reset pin and source checks.

    AST_PIN_SENSED: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        !s_r.pin_sync_b |=> s_r.phase == ST_ACTIVE)
        else $error("Low reset pin not sensed.");

    AST_LATCH: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        EXT_RESET_LATCH_I |=> s_r.phase == ST_ACTIVE && !RESET_PIN_OE_N_O)
        else $error("Latched pulse did not start a reset.");

    AST_EXT_WIDTH: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        EXT_RESET_LATCH_I |=> s_r.width_cnt == 8'(OUT_WIDTH_CYC))
        else $error("External pulse not stretched.");

    AST_STRETCH: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.width_cnt != 8'h00 |-> s_r.phase == ST_ACTIVE && !RESET_PIN_OE_N_O)
        else $error("Pin released before minimum width.");

    AST_WIDTH_DOWN: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.width_cnt != 8'h00 && !ext_req && !WATCHDOG_UNDERFLOW_I |=>
        s_r.width_cnt == $past(s_r.width_cnt) - 8'h01)
        else $error("Width counter did not count down.");

    AST_LVD_PIN: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        LOW_VOLTAGE_DETECTOR_I |=> !RESET_PIN_OE_N_O)
        else $error("Low-voltage reset did not hold the pin.");

    AST_RUN_NO_DRIVE: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        CPU_RUN_O |-> RESET_PIN_OE_N_O)
        else $error("Pin driven while running.");

    // Sequence checks.

    AST_ACTIVE_TO_DELAY: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.phase == ST_ACTIVE ##1 s_r.phase != ST_ACTIVE |-> s_r.phase == ST_DELAY)
        else $error("Active phase not followed by delay.");

    AST_DELAY_TO_FETCH: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.phase == ST_DELAY ##1 s_r.phase != ST_DELAY |->
        s_r.phase inside {ST_FETCH, ST_ACTIVE})
        else $error("Delay not followed by fetch.");

    AST_VRD_ONLY_FETCH: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        VEC_RD_O |-> s_r.phase == ST_FETCH)
        else $error("Vector read outside fetch.");

    AST_DELAY_FROM_ZERO: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        $rose(s_r.phase == ST_DELAY) |-> s_r.cnt == 13'h0000)
        else $error("Delay count did not start at zero.");

    AST_DELAY_CAP: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.phase == ST_DELAY |-> s_r.cnt < delay_len)
        else $error("Delay count beyond its length.");

    AST_DELAY_LONG: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        LONG_DELAY_OPT_I && $rose(s_r.phase == ST_FETCH) |-> low_cnt >= 4096)
        else $error("Long delay shorter than 4096 cycles.");

    AST_FETCH_REL: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.phase == ST_FETCH |-> RESET_PIN_OE_N_O)
        else $error("Pin still driven during fetch.");

    AST_RUN_AFTER_FETCH: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        s_r.phase == ST_FETCH && s_r.cnt == 13'h0001 && !src_active |=> CPU_RUN_O)
        else $error("Execution did not start after fetch.");

    AST_RUN_PC: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        $rose(CPU_RUN_O) |-> s_r.phase == ST_RUN && $past(s_r.phase) == ST_FETCH)
        else $error("Run began without a fetch.");

    AST_PC_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        CPU_RUN_O && !src_active |=> $stable(START_PC_O))
        else $error("Start address changed while running.");

endmodule : rcm_top

// *** dv/rcm_board_model.sv ***
// Board reset circuitry: open-drain reset line with pull-up and the pad's pulse latch.
`timescale 1ns/1ps
module rcm_board_model (
    input wire logic oe_n_i,
    input wire logic pull_low_i,
    output logic pin_o,
    output logic latch_o
);
    // Line is low if either party pulls it, else the pull-up wins.
    assign pin_o = (!oe_n_i || pull_low_i) ? 1'b0 : 1'b1;
    initial latch_o = 1'b0;
    always @(posedge pull_low_i) latch_o = 1'b1;
    always @(negedge oe_n_i) latch_o = 1'b0;
endmodule : rcm_board_model

// *** dv/rcm_top_bench.sv ***
// Self-checking bench of the reset sequencer and clock source selector.
`timescale 1ns/1ps
module rcm_top_bench;
    import rcm_pkg::*;
    localparam int W = 2;
    typedef struct packed {logic [15:0] pc; logic [12:0] n;} rcm_exp_t;
    logic clk = 0, srst = 1, dbl = 0, lng = 0, osc = 0, dclk = 0, low_voltage_detector = 0, wdg = 0, pull = 0;
    logic [2:0] src = 3'h1;
    logic [7:0] vdat = 8'h00, lo = 8'h00, hi = 8'h00;
    logic pin, latch, oe_n, run, vrd, dact, ren, clko, rpo, run_q = 0, ck_q = 0;
    logic [15:0] vaddr, pc;
    logic [1:0] ph;
    logic [31:0] seed = 96715;
    rcm_exp_t expq[$];
    rcm_exp_t e;
    int miscompares = 0, n_compared = 0, cyc = 0, dly = 0, fi = 0, tg = 0;
    rcm_top #(.OUT_WIDTH_CYC(W)) dut_u (.CORE_CLK_I(clk), .SRST_I(srst),
        .CLOCK_SOURCE_SELECT_I(src), .DOUBLER_OPT_I(dbl), .LONG_DELAY_OPT_I(lng),
        .SELECTED_OSC_CLK_I(osc), .DOUBLER_CLK_I(dclk), .RESET_PIN_I(pin),
        .EXT_RESET_LATCH_I(latch), .LOW_VOLTAGE_DETECTOR_I(low_voltage_detector),
        .WATCHDOG_UNDERFLOW_I(wdg), .VEC_DATA_I(vdat), .RESET_PIN_O(rpo),
        .RESET_PIN_OE_N_O(oe_n), .DOUBLED_OR_HALVED_CLOCK_O(clko), .DOUBLER_ACTIVE_O(dact),
        .RESONATOR_EN_O(ren), .VEC_RD_O(vrd), .VEC_ADDR_O(vaddr), .START_PC_O(pc),
        .CPU_RUN_O(run), .PHASE_O(ph));
    rcm_board_model board_u (.oe_n_i(oe_n), .pull_low_i(pull), .pin_o(pin), .latch_o(latch));
    initial begin
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    // Queues the expected start address and delay, then lets the sequence run out.
    task automatic boot(input logic [12:0] n);
        lo = seed[7:0];
        seed = lfsr(seed);
        hi = seed[7:0];
        seed = lfsr(seed);
        expq.push_back({lo, hi, n});
        repeat (n + 40) @(negedge clk);
    endtask : boot
    always @(negedge clk) begin
        osc <= ~osc;
        dclk <= ~dclk;
        vdat <= (vaddr === 16'hfffe) ? lo : hi;
    end
    always @(posedge clk) begin
        if (ph === 2'd0) begin
            dly = 0;
            fi = 0;
        end
        if (ph === 2'd1) begin
            dly++;
            check(oe_n, 0);
        end
        if (vrd === 1'b1) begin
            check(vaddr, fi ? 16'hffff : 16'hfffe);
            fi++;
        end
        if (run === 1'b1 && run_q !== 1'b1) begin
            e = expq.pop_front();
            check(pc, e.pc);
            check(dly, e.n);
            check(fi, 2);
        end
        run_q <= run;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        srst = 0;
        boot(13'd256);
        for (int s = 0; s < 6; s++) begin
            srst = 1;
            src = s[2:0];
            dbl = s[1] || s == 5;
            lng = s[0];
            repeat (3) @(negedge clk);
            srst = 0;
            repeat (2) @(negedge clk);
            check(dact, dbl && s != 5);
            check(ren, s >= 1 && s <= 4);
            tg = 0;
            ck_q = clko;
            repeat (8) begin
                @(negedge clk);
                if (clko !== ck_q) tg++;
                ck_q = clko;
            end
            check(tg, (dbl && s != 5) ? 8 : 4);
            boot(lng ? 13'd4096 : 13'd256);
        end
        for (int k = 0; k < 3; k++) begin
            {low_voltage_detector, wdg, pull} = 3'b001 << k;
            repeat (k == 2 ? 30 : 1) @(negedge clk);
            check(ph, 0);
            check(oe_n, 0);
            check(pin, 0);
            check(rpo, 0);
            {low_voltage_detector, wdg, pull} = 3'h0;
            repeat (W - 1) @(negedge clk);
            check(ph, k == 2);
            check(oe_n, 0);
            boot(13'd256);
        end
        end_of_test();
    end
endmodule : rcm_top_bench
